// File: sfr_pkg.sv
// Shared constants, timing figures and state types for the fault retry and diagnostic block.
package sfr_pkg;

   // ----------------------------------------------------------------------
   // Clock and time base
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS  = 1000000;
   localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // Retry counter and periods
   // ----------------------------------------------------------------------
   localparam int             CNT_W       = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
   localparam logic [CNT_W-1:0] RETRY_LIMIT = 4'hF;
   localparam int             TMR_W       = 8;
   localparam logic [TMR_W-1:0] RETRY_PERIOD0_MS = 8'h0A;
   localparam logic [TMR_W-1:0] RETRY_PERIOD1_MS = 8'h14;
   localparam logic [TMR_W-1:0] RETRY_PERIOD2_MS = 8'h28;
   localparam logic [TMR_W-1:0] RETRY_PERIOD3_MS = 8'h50;
   localparam logic [TMR_W-1:0] OL_INTERVAL_MS   = 8'h96;

   // Retry period selection from the two-bit period field.
   function automatic logic [TMR_W-1:0] retry_period_ms(input logic [1:0] sel);
      case (sel)
         2'h0:    retry_period_ms = RETRY_PERIOD0_MS;
         2'h1:    retry_period_ms = RETRY_PERIOD1_MS;
         2'h2:    retry_period_ms = RETRY_PERIOD2_MS;
         default: retry_period_ms = RETRY_PERIOD3_MS;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Per-channel retry sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_WAIT_CLEAR,
      ST_WAIT_PERIOD,
      ST_LATCHED
   } retry_state_e;

endpackage

// File: sync2.sv
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// File: ms_timer.sv
// Millisecond down-counter with a one-cycle done pulse and an expired level.
`timescale 1ns/1ps
module ms_timer #(
   parameter int W            = 8,
   parameter bit EXPIRED_INIT = 1'b0
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         tick,
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   output logic              done,
   output logic              expired
);
   logic [W-1:0] count_r;
   logic         running_r;
   // The first tick after start is only a partial one, so the count runs down to zero and one tick more.
   // The interval therefore never ends before the loaded number of ticks has fully elapsed.
   wire          last_tick = running_r && tick && (count_r == '0);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_r   <= '0;
         running_r <= 1'b0;
         done      <= 1'b0;
         expired   <= EXPIRED_INIT;
      end else begin
         done <= last_tick && !start;
         if (start) begin
            count_r   <= load;
            running_r <= 1'b1;
            expired   <= 1'b0;
         end else if (last_tick) begin
            running_r <= 1'b0;
            expired   <= 1'b1;
         end else if (running_r && tick) begin
            count_r <= count_r - {{(W-1){1'b0}}, 1'h1};
         end
      end
   end
endmodule

// File: switch_fault_retry_diag.sv
// Two-channel fault retry sequencer with open-load and short-to-supply diagnostics.
//
// Summary of operation
// - Only overcurrent, severe short, overtemperature or undervoltage start a retry.
// - Overtemperature and undervoltage retries wait until the cause has gone.
// - With retry disabled, any latchable fault latches the channel off at once.
// - Retry is enabled when the polarity bit equals the load type select.
// - A retry sequence starts only with fault control high and a retry condition.
// - The channel turns back on after the selected retry period.
// - A cleared fault restores normal output; the fault bit stays until read.
// - Unlimited mode retries forever; with retry enabled and fault control high it never latches off.
// - Limited mode counts retries in four bits; fifteen retries set the exhausted flag.
// - After exhaustion one more retry; a persisting fault latches off, status low.
// - The host may delatch at any time; the retry counter is kept.
// - Fail-safe, sleep exit, reset, unlimited set or retry disable clear the counter.
// - A latched channel is released when unlimited mode clears the counter.
// - Lamp loads reset overcurrent duration at each retry, motors after a clean period.
// - Off-state short to supply sets a flag and shows live on status, no turn-off.
// - The short flag holds until the fault register is read; it can be disabled.
// - Off-state open load sets a flag held until read, status live, can be disabled.
// - High sense ratio checks on-state open load continuously, channel stays on.
// - High ratio read clears on-state open load when off, or when cause gone.
// - Low ratio internal control checks at turn-off every interval, fast slew only.
// - Low ratio direct control checks at each turn-off, fast slew only; clears only after clean check.
`timescale 1ns/1ps
module switch_fault_retry_diag #(
   parameter int TICK_CYCLES = sfr_pkg::TICK_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [1:0] overcurrent_fault,
   input  wire logic [1:0] severe_short_fault,
   input  wire logic [1:0] overtemp_fault,
   input  wire logic       undervoltage_fault,
   input  wire logic [1:0] load_type_select,
   input  wire logic [1:0] short_supply_sense,
   input  wire logic [1:0] openload_off_sense,
   input  wire logic [1:0] load_current_low,
   input  wire logic [1:0] fault_control,
   input  wire logic [1:0] delatch_request,
   input  wire logic [1:0] channel_request,
   input  wire logic [1:0] retry_polarity_bit,
   input  wire logic [1:0] unlimited_retry_bit,
   input  wire logic [3:0] retry_period_sel,
   input  wire logic       failsafe_entry,
   input  wire logic       sleep_exit,
   input  wire logic       fault_reg_read,
   input  wire logic [1:0] short_detect_disable,
   input  wire logic [1:0] offstate_openload_disable,
   input  wire logic [1:0] onstate_openload_disable,
   input  wire logic [1:0] low_current_sense_ratio,
   input  wire logic [1:0] fast_slew,
   input  wire logic [1:0] direct_input_disable,
   input  wire logic [1:0] turn_off_event,
   input  wire logic [1:0] full_duty,
   output logic [1:0]      channel_on,
   output logic            fault_status_out_n,
   output logic [7:0]      retry_count,
   output logic [1:0]      retry_exhausted_flag,
   output logic [1:0]      latched_off,
   output logic [1:0]      fault_bit,
   output logic [1:0]      output_short_supply_flag,
   output logic [1:0]      offstate_openload_flag,
   output logic [1:0]      onstate_openload_flag,
   output logic [1:0]      oc_duration_reset
);
   localparam int TICK_W = $clog2(TICK_CYCLES + 1);

   // ----------------------------------------------------------------------
   // Pin synchronisers and millisecond tick
   // ----------------------------------------------------------------------
   logic [1:0] oc_s;
   logic [1:0] sc_s;
   logic [1:0] ot_s;
   logic       uv_s;
   logic [1:0] load_s;
   logic [1:0] short_s;
   logic [1:0] oloff_s;
   logic [1:0] low_s;

   sync2 #(.W(15)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({overcurrent_fault, severe_short_fault, overtemp_fault, undervoltage_fault,
               load_type_select, short_supply_sense, openload_off_sense, load_current_low}),
      .q     ({oc_s, sc_s, ot_s, uv_s, load_s, short_s, oloff_s, low_s})
   );

   logic [TICK_W-1:0] prescale_r;
   wire               tick = (prescale_r == TICK_W'(TICK_CYCLES - 1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prescale_r <= '0;
      end else begin
         prescale_r <= tick ? '0 : prescale_r + TICK_W'(1);
      end
   end

   // ----------------------------------------------------------------------
   // Per-channel state
   // ----------------------------------------------------------------------
   sfr_pkg::retry_state_e           st_r   [2];
   sfr_pkg::retry_state_e           st_nxt [2];
   logic [sfr_pkg::CNT_W-1:0]       cnt_r  [2];
   logic [sfr_pkg::CNT_W-1:0]       cnt_nxt[2];
   logic [1:0] final_used_r;
   logic [1:0] pol_prev_r;
   logic [1:0] unl_prev_r;
   logic [1:0] oc_seen_r;
   logic [1:0] dur_pending_r;
   logic [1:0] clean_check_r;
   logic [1:0] tmr_done;
   logic [1:0] ol_due;
   logic [1:0] live_fault;

   assign retry_count = {cnt_r[1], cnt_r[0]};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fault_status_out_n <= 1'b1;
      end else begin
         fault_status_out_n <= ~|live_fault;
      end
   end

   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      // Fault decoding and retry qualifiers.
      wire fault_any = oc_s[ch] | sc_s[ch] | ot_s[ch] | uv_s;
      wire slow      = ot_s[ch] | uv_s;
      wire retry_en  = (retry_polarity_bit[ch] == load_s[ch]);
      wire unl       = unlimited_retry_bit[ch];
      wire unl_rise  = unl && !unl_prev_r[ch];
      wire dis_edge  = load_s[ch] ? (pol_prev_r[ch] && !retry_polarity_bit[ch])
                                  : (!pol_prev_r[ch] && retry_polarity_bit[ch]);
      wire cnt_clear = failsafe_entry | sleep_exit | unl_rise | dis_edge;
      wire can_retry = unl | !retry_exhausted_flag[ch] | !final_used_r[ch];
      wire in_normal = (st_r[ch] == sfr_pkg::ST_NORMAL);
      wire go_retry  = in_normal && fault_any && retry_en && fault_control[ch] && can_retry;
      wire go_latch  = in_normal && fault_any && !go_retry;
      wire tmr_start = (st_nxt[ch] == sfr_pkg::ST_WAIT_PERIOD) && (st_r[ch] != sfr_pkg::ST_WAIT_PERIOD);
      wire retry_done = tmr_done[ch] && (st_r[ch] == sfr_pkg::ST_WAIT_PERIOD);
      wire on_nxt    = channel_request[ch] && (st_nxt[ch] == sfr_pkg::ST_NORMAL);

      always_comb begin
         case (st_r[ch])
            sfr_pkg::ST_NORMAL:
               if (go_latch)
                  st_nxt[ch] = sfr_pkg::ST_LATCHED;
               else if (go_retry)
                  st_nxt[ch] = slow ? sfr_pkg::ST_WAIT_CLEAR : sfr_pkg::ST_WAIT_PERIOD;
               else
                  st_nxt[ch] = sfr_pkg::ST_NORMAL;
            sfr_pkg::ST_WAIT_CLEAR:
               st_nxt[ch] = slow ? sfr_pkg::ST_WAIT_CLEAR : sfr_pkg::ST_WAIT_PERIOD;
            sfr_pkg::ST_WAIT_PERIOD:
               st_nxt[ch] = tmr_done[ch] ? sfr_pkg::ST_NORMAL : sfr_pkg::ST_WAIT_PERIOD;
            sfr_pkg::ST_LATCHED:
               if (unl_rise)
                  st_nxt[ch] = retry_en ? sfr_pkg::ST_WAIT_PERIOD : sfr_pkg::ST_NORMAL;
               else
                  st_nxt[ch] = sfr_pkg::ST_LATCHED;
            default:
               st_nxt[ch] = sfr_pkg::ST_NORMAL;
         endcase
         if (delatch_request[ch]) begin
            st_nxt[ch] = sfr_pkg::ST_NORMAL;
         end
      end

      // Counting stops at fifteen so a long fault never wraps back to a fresh budget.
      always_comb begin
         cnt_nxt[ch] = cnt_r[ch];
         if (cnt_clear)
            cnt_nxt[ch] = sfr_pkg::CNT_ZERO;
         else if (retry_done && !unl && cnt_r[ch] != sfr_pkg::RETRY_LIMIT)
            cnt_nxt[ch] = cnt_r[ch] + sfr_pkg::CNT_ONE;
      end

      ms_timer #(.W(sfr_pkg::TMR_W), .EXPIRED_INIT(1'b0)) u_retry_tmr (
         .clock   (clock),
         .rst_n   (rst_n),
         .tick    (tick),
         .start   (tmr_start),
         .load    (sfr_pkg::retry_period_ms(retry_period_sel[2*ch+:2])),
         .done    (tmr_done[ch]),
         .expired ()
      );

      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            st_r[ch]                 <= sfr_pkg::ST_NORMAL;
            cnt_r[ch]                <= sfr_pkg::CNT_ZERO;
            retry_exhausted_flag[ch] <= 1'b0;
            final_used_r[ch]         <= 1'b0;
            pol_prev_r[ch]           <= 1'b0;
            unl_prev_r[ch]           <= 1'b0;
            channel_on[ch]           <= 1'b0;
            latched_off[ch]          <= 1'b0;
         end else begin
            st_r[ch]       <= st_nxt[ch];
            cnt_r[ch]      <= cnt_nxt[ch];
            pol_prev_r[ch] <= retry_polarity_bit[ch];
            unl_prev_r[ch] <= unl;
            channel_on[ch] <= on_nxt;
            latched_off[ch] <= (st_nxt[ch] == sfr_pkg::ST_LATCHED);
            retry_exhausted_flag[ch] <= !cnt_clear && !unl &&
                                        (cnt_nxt[ch] == sfr_pkg::RETRY_LIMIT);
            if (cnt_clear)
               final_used_r[ch] <= 1'b0;
            else if (go_retry && retry_exhausted_flag[ch] && !unl)
               final_used_r[ch] <= 1'b1;
         end
      end

      // ------------------------------------------------------------------
      // Overcurrent duration reset and sticky fault bit
      // ------------------------------------------------------------------
      wire clean_off = turn_off_event[ch] && !oc_seen_r[ch] && !oc_s[ch];

      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            oc_seen_r[ch]         <= 1'b0;
            dur_pending_r[ch]     <= 1'b0;
            oc_duration_reset[ch] <= 1'b0;
            fault_bit[ch]         <= 1'b0;
         end else begin
            oc_seen_r[ch]         <= turn_off_event[ch] ? 1'b0 : (oc_seen_r[ch] | oc_s[ch]);
            dur_pending_r[ch]     <= load_s[ch] && (retry_done || (dur_pending_r[ch] && !clean_off));
            oc_duration_reset[ch] <= load_s[ch] ? (dur_pending_r[ch] && clean_off) : retry_done;
            fault_bit[ch]         <= fault_any || (fault_bit[ch] && !fault_reg_read);
         end
      end

      // ------------------------------------------------------------------
      // Diagnostics
      // ------------------------------------------------------------------
      wire off_st     = !channel_on[ch];
      wire hi_ratio   = !low_current_sense_ratio[ch];
      wire os_live    = off_st && !short_detect_disable[ch] && short_s[ch];
      wire oloff_live = off_st && !offstate_openload_disable[ch] && oloff_s[ch];
      wire onstate_openload_flag_hi    = channel_on[ch] && hi_ratio && !onstate_openload_disable[ch] && low_s[ch];
      wire lo_arm     = !hi_ratio && fast_slew[ch] && !onstate_openload_disable[ch];
      wire chk_int    = lo_arm && direct_input_disable[ch] && ol_due[ch] &&
                        (turn_off_event[ch] || (full_duty[ch] && channel_on[ch]));
      wire chk_dir    = lo_arm && !direct_input_disable[ch] && turn_off_event[ch];
      wire ol_check   = chk_int || chk_dir;
      wire onstate_openload_flag_clr   = hi_ratio ? (fault_reg_read && (off_st || !low_s[ch]))
                                 : (fault_reg_read && clean_check_r[ch]);

      // The interval starts out expired so the first low-ratio check is not held back.
      ms_timer #(.W(sfr_pkg::TMR_W), .EXPIRED_INIT(1'b1)) u_ol_tmr (
         .clock   (clock),
         .rst_n   (rst_n),
         .tick    (tick),
         .start   (chk_int),
         .load    (sfr_pkg::OL_INTERVAL_MS),
         .done    (),
         .expired (ol_due[ch])
      );

      assign live_fault[ch] = latched_off[ch] | os_live | oloff_live | onstate_openload_flag_hi;

      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            output_short_supply_flag[ch] <= 1'b0;
            offstate_openload_flag[ch]   <= 1'b0;
            onstate_openload_flag[ch]    <= 1'b0;
            clean_check_r[ch]            <= 1'b0;
         end else begin
            output_short_supply_flag[ch] <= os_live || (output_short_supply_flag[ch] && !fault_reg_read);
            offstate_openload_flag[ch]   <= oloff_live || (offstate_openload_flag[ch] && !fault_reg_read);
            onstate_openload_flag[ch]    <= onstate_openload_flag_hi || (ol_check && low_s[ch]) ||
                                            (onstate_openload_flag[ch] && !onstate_openload_flag_clr);
            if (ol_check)
               clean_check_r[ch] <= !low_s[ch];
         end
      end

      // ------------------------------------------------------------------
      // Assertions
      // ------------------------------------------------------------------
      AST_RETRY_CAUSE: assert property (@(posedge clock) disable iff (!rst_n)
         (in_normal && !delatch_request[ch]) ##1 (st_r[ch] != sfr_pkg::ST_NORMAL) |-> $past(fault_any))
         else $error("Channel left normal without a latchable fault.");
      AST_SLOW_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
         (st_r[ch] == sfr_pkg::ST_WAIT_CLEAR && slow && !delatch_request[ch]) |=>
         (st_r[ch] == sfr_pkg::ST_WAIT_CLEAR))
         else $error("Retry period started while the slow fault was present.");
      AST_LATCH_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
         (in_normal && fault_any && !retry_en && !delatch_request[ch]) |=> ##1 latched_off[ch])
         else $error("Fault with retry disabled did not latch.");
      AST_ENABLED_NO_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
         (in_normal && fault_any && retry_en && fault_control[ch] && can_retry) |=>
         (st_r[ch] != sfr_pkg::ST_LATCHED))
         else $error("Enabled retry latched instead.");
      AST_START_NEEDS_CONTROL: assert property (@(posedge clock) disable iff (!rst_n)
         in_normal ##1 (st_r[ch] inside {sfr_pkg::ST_WAIT_PERIOD, sfr_pkg::ST_WAIT_CLEAR}) |->
         $past(fault_control[ch]))
         else $error("Retry started without fault control.");
      AST_PERIOD_BACK_ON: assert property (@(posedge clock) disable iff (!rst_n)
         (retry_done && channel_request[ch]) |=> channel_on[ch])
         else $error("Channel not back on after retry period.");
      AST_UNLIMITED: assert property (@(posedge clock) disable iff (!rst_n)
         (unl && unl_prev_r[ch] && in_normal && fault_any && retry_en && fault_control[ch]) |=>
         (st_r[ch] != sfr_pkg::ST_LATCHED))
         else $error("Unlimited mode latched a channel.");
      AST_EXHAUSTED: assert property (@(posedge clock) disable iff (!rst_n)
         (cnt_r[ch] == sfr_pkg::RETRY_LIMIT) |-> retry_exhausted_flag[ch])
         else $error("Counter at limit without exhausted flag.");
      AST_FINAL_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
         (in_normal && fault_any && retry_exhausted_flag[ch] && final_used_r[ch] && !unl &&
          !delatch_request[ch]) |=> ##1 (latched_off[ch] && !fault_status_out_n))
         else $error("Fault after final retry did not latch with status low.");
      AST_COUNT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
         cnt_clear |=> (cnt_r[ch] == sfr_pkg::CNT_ZERO))
         else $error("Retry counter not cleared.");
      AST_SATURATE: assert property (@(posedge clock) disable iff (!rst_n)
         (cnt_r[ch] == sfr_pkg::RETRY_LIMIT && !cnt_clear) |=> (cnt_r[ch] == sfr_pkg::RETRY_LIMIT))
         else $error("Retry counter wrapped.");
      AST_SHORT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
         (output_short_supply_flag[ch] && !fault_reg_read) |=> output_short_supply_flag[ch])
         else $error("Short flag lost before a read.");
      AST_SHORT_STATUS: assert property (@(posedge clock) disable iff (!rst_n)
         os_live |=> !fault_status_out_n)
         else $error("Short to supply not shown on status.");
      AST_ONSTATE_OPENLOAD_FLAG_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
         (onstate_openload_flag[ch] && hi_ratio && channel_on[ch] && low_s[ch]) |=>
         onstate_openload_flag[ch])
         else $error("On-state open-load flag cleared while cause present.");

      COV_EXHAUSTED: cover property (@(posedge clock) disable iff (!rst_n) $rose(retry_exhausted_flag[ch]));
      COV_FINAL_LATCH: cover property (@(posedge clock) disable iff (!rst_n)
         final_used_r[ch] ##[1:1000] $rose(latched_off[ch]));
      COV_SHORT: cover property (@(posedge clock) disable iff (!rst_n) $rose(output_short_supply_flag[ch]));
      COV_LOW_CHECK: cover property (@(posedge clock) disable iff (!rst_n) chk_int);
   end
endmodule

// File: host_model.sv
// Host-side model that turns bench commands into fault read and delatch pulses.
`timescale 1ns/1ps
module host_model (
   input  wire logic       clock,
   input  wire logic       read_cmd,
   input  wire logic       delatch_cmd,
   output logic            fault_reg_read,
   output logic [1:0]      delatch_request
);
   logic rd_q;
   logic dl_q;
   initial begin
      rd_q = 1'b0;
      dl_q = 1'b0;
      fault_reg_read = 1'b0;
      delatch_request = 2'h0;
   end
   // Pulses launch on the falling edge so the block samples them clear of its own edge.
   always @(negedge clock) begin
      rd_q <= read_cmd;
      dl_q <= delatch_cmd;
      fault_reg_read <= read_cmd & ~rd_q;
      delatch_request <= {2{delatch_cmd & ~dl_q}};
   end
endmodule

// File: tb.sv
// Self-checking bench for the fault retry and diagnostic block.
`timescale 1ns/1ps
module tb;
   logic       clock = 0, rst_n = 0, uv = 0, fs = 0, rdc = 0, dlc = 0, rd;
   logic [1:0] oc = 0, ot = 0, lt = 0, ss = 0, ll = 0, req = 2'h3, pol = 0, un = 0, dl;
   logic [3:0] ps = 4'h0;
   logic [2:0] rows [4] = '{3'h0, 3'h3, 3'h5, 3'h6};
   wire  [1:0] on, lat, ex, fb, osf, ofl, onl, odr;
   wire        st_n;
   wire  [7:0] cnt;
   int         fails = 0, samples_checked = 0, n, odr_n = 0;
   always #50 clock = ~clock;
   // Duration-reset pulses last one cycle, so each one is counted once at a falling edge.
   always @(negedge clock) odr_n += odr[0];
   host_model host (.clock(clock), .read_cmd(rdc), .delatch_cmd(dlc), .fault_reg_read(rd), .delatch_request(dl));
   switch_fault_retry_diag #(.TICK_CYCLES(10)) DUT (.clock(clock), .rst_n(rst_n), .overcurrent_fault(oc),
      .severe_short_fault(2'h0), .overtemp_fault(ot), .undervoltage_fault(uv), .load_type_select(lt),
      .short_supply_sense(ss), .openload_off_sense(ss & 2'h2), .load_current_low(ll), .fault_control(req),
      .delatch_request(dl), .channel_request(req), .retry_polarity_bit(pol), .unlimited_retry_bit(un),
      .retry_period_sel(ps), .failsafe_entry(fs), .sleep_exit(uv), .fault_reg_read(rd),
      .short_detect_disable(2'h0), .offstate_openload_disable(un), .onstate_openload_disable(un),
      .low_current_sense_ratio(pol), .fast_slew(lt), .direct_input_disable(lt), .turn_off_event(oc),
      .full_duty(req), .channel_on(on), .fault_status_out_n(st_n), .retry_count(cnt),
      .retry_exhausted_flag(ex), .latched_off(lat), .fault_bit(fb), .output_short_supply_flag(osf),
      .offstate_openload_flag(ofl), .onstate_openload_flag(onl), .oc_duration_reset(odr));
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // A short overcurrent burst on channel 0, then a settle time of w cycles.
   task automatic fault(input int w);
      @(negedge clock) oc = 2'h1;
      repeat (4) @(negedge clock);
      oc = 2'h0;
      repeat (w) @(negedge clock);
   endtask
   task automatic cmd_pulse(input bit read);
      @(negedge clock);
      if (read) rdc <= 1'b1; else dlc <= 1'b1;
      repeat (2) @(negedge clock);
      rdc <= 1'b0;
      dlc <= 1'b0;
      repeat (4) @(negedge clock);
   endtask
   // Bounded wait on channel 0 output; running out ends the run.
   task automatic wait_on(input logic v);
      n = 0;
      while (on[0] !== v && n < 400) begin
         @(negedge clock);
         n++;
      end
      if (n == 400) begin
         fails++;
         test_done();
      end
   endtask
   initial begin
      repeat (20) @(negedge clock);
      chk("status_in_reset", st_n, 1);
      chk("count_in_reset", cnt, 0);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      foreach (rows[i]) begin
         lt = {2{rows[i][2]}};
         pol = {2{rows[i][1]}};
         fault(8);
         chk("latched", lat[0], rows[i][0]);
         chk("status_latched", st_n, !rows[i][0]);
         cmd_pulse(1'b0);
         repeat (140) @(negedge clock);
         chk("on_after_recovery", on[0], 1);
      end
      $display("test retry enable table done");
      @(negedge clock) fs = 1'b1;
      @(negedge clock) fs = 1'b0;
      fault(0);
      wait_on(1'b0);
      wait_on(1'b1);
      chk("period_in_range", n >= 95 && n <= 118, 1);
      chk("count_one", cnt[3:0], 1);
      repeat (14) fault(140);
      chk("exhausted", ex[0], 1);
      fault(140);
      chk("final_retry", lat[0], 0);
      fault(8);
      chk("latched_final", lat[0], 1);
      chk("status_final", st_n, 0);
      chk("oc_duration_resets", odr_n, 16);
      $display("test retry count done");
      @(negedge clock) un = 2'h1;
      repeat (4) @(negedge clock);
      chk("count_cleared", cnt[3:0], 0);
      chk("delatched", lat[0], 0);
      req = 2'h0;
      ss = 2'h3;
      repeat (6) @(negedge clock);
      chk("short_flag", osf[0], 1);
      chk("offstate_ol_flag", ofl[1], 1);
      chk("short_status", st_n, 0);
      ss = 2'h0;
      repeat (6) @(negedge clock);
      chk("short_held", osf[0], 1);
      chk("offstate_ol_held", ofl[1], 1);
      chk("status_live", st_n, 1);
      cmd_pulse(1'b1);
      chk("short_read", osf[0], 0);
      chk("fault_bit_read", fb[0], 0);
      chk("offstate_ol_read", ofl[1], 0);
      $display("test diagnostics done");
      pol = 2'h0;
      req = 2'h3;
      ll = 2'h2;
      repeat (6) @(negedge clock);
      chk("onstate_openload_flag_flag", onl[1], 1);
      chk("onstate_openload_flag_status", st_n, 0);
      chk("onstate_openload_flag_stays_on", on[1], 1);
      cmd_pulse(1'b1);
      chk("onstate_openload_flag_read_cause", onl[1], 1);
      ll = 2'h0;
      repeat (6) @(negedge clock);
      chk("onstate_openload_flag_status_live", st_n, 1);
      cmd_pulse(1'b1);
      chk("onstate_openload_flag_read_clear", onl[1], 0);
      $display("test on-state open load done");
      test_done();
   end
endmodule
